// >>> core/hpcc_top.sv
// hierarchical performance counter control: boxes, monitor hub, freeze and interrupt
`timescale 1ns/10ps
`include "hpcc_cfg.svh"

// Notes on behaviour
// - a wrapping counter reports to the hub only with overflow_report_allow set
// - hub records every report in a per-box global status bit
// - a report makes the hub raise the global freeze
// - global freeze stops every box counter
// - a report pulses monitor_interrupt to the cores in interrupt_target_cores
// - after reset every counter is disabled
// - writing 1 to halt_all_counting freezes all boxes
// - halt_box_counting set to 1 freezes only that box
// - a counter counts only while its count_gate_on bit is 1
// - event_code, event_subfilter, count_limit_compare, rising_only_count select the event
// - per-box opcode match filter further qualifies events
// - writing 0x3 to unit_control_reg[1:0] clears counts and control registers
// - hub has no unit control; its counters clear by writing 0
// - counter data registers are writable for preloading a sample interval
// - hub fixed counter counts each clock while enabled and not frozen
// - writing 1 to resume_all_counting releases the global freeze
// - writing 0 to halt_box_counting releases that box
// - hub counters count once enabled with valid event, no box freeze
// - overflow held per box globally and per counter in wrap_flag_bits
// - several counters wrapping together set every flag
// - each box is an independent monitoring block with its own status
// - global status bits clear on writing 1, 0 leaves them
// - new freeze only after box and global flags are cleared
// - interrupt_target_cores is an 18-bit mask, one bit per core
module hpcc_top
    import hpcc_pkg::*;
#(
    parameter int NUM_BOX = 2,
    parameter int NUM_CTR = 2,
    parameter int CTR_W   = 48,
    parameter int TGT_W   = 18
) (
    input  wire logic                                 i_clk_sys,
    input  wire logic                                 i_sys_rst,
    input  wire logic [`HPCC_ADDR_W-1:0]              i_addr,
    input  wire logic [31:0]                          i_wdata,
    input  wire logic                                 i_wr,
    input  wire logic                                 i_rd,
    input  wire logic [(NUM_BOX+1)*`HPCC_EV_LINES-1:0] i_unit_events,
    input  wire logic [(NUM_BOX+1)*8-1:0]             i_unit_attr,
    input  wire logic [(NUM_BOX+1)*8-1:0]             i_unit_opcode,
    input  wire logic [(NUM_BOX+1)*`HPCC_LVL_W-1:0]   i_unit_level,
    output logic      [31:0]                          o_rdata,
    output logic                                      o_global_freeze,
    output logic      [TGT_W-1:0]                     o_monitor_interrupt
);
    localparam int NU = NUM_BOX + 1;
    localparam int NT = NU * NUM_CTR;
    localparam int SW = NU * (8 + 8 + 8 + `HPCC_LVL_W);

    initial begin
        if (NUM_BOX < 1 || NU > 31 || NUM_CTR < 1 || NUM_CTR > 4 || CTR_W < 33 || CTR_W > 48
            || TGT_W < 1 || TGT_W > 18) begin
            $error("hpcc_top: parameter out of range");
        end
    end

    function automatic logic hpcc_sel(input logic [`HPCC_ADDR_W-1:0] a, input int u,
                                      input logic [5:0] ofs);
        hpcc_sel = (a[`HPCC_ADDR_W-1:`HPCC_UNIT_SHIFT] == 6'(u + 1))
                   && (a[`HPCC_UNIT_SHIFT-1:0] == ofs);
    endfunction

    // ************************************************
    // pin synchronisers
    // ************************************************
    logic [SW-1:0] pin_meta;
    logic [SW-1:0] pin_sync;
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= {i_unit_events, i_unit_attr, i_unit_opcode, i_unit_level};
            pin_sync <= pin_meta;
        end
    end
    logic [NU*`HPCC_EV_LINES-1:0] ev_s;
    logic [NU*8-1:0]              attr_s;
    logic [NU*8-1:0]              op_s;
    logic [NU*`HPCC_LVL_W-1:0]    lvl_s;
    assign {ev_s, attr_s, op_s, lvl_s} = pin_sync;

    // ************************************************
    // global control and status
    // ************************************************
    logic             gfrz;
    logic [TGT_W-1:0] targets;
    logic [NU-1:0]    gstat;
    logic             gstat_fix;
    logic [NU-1:0]    rep;
    logic             rep_fix;
    logic             resp;
    logic             trigger;
    logic [CTR_W-1:0] cnt [NT];
    hpcc_word_t       ctl [NT];
    logic [NT-1:0]    wflag;
    logic [NT-1:0]    wrap;
    logic [NU-1:0]    halt_box;
    hpcc_byte_t       filt [NU];
    logic [CTR_W-1:0] fcnt;
    logic             fgate;
    logic             fallow;
    logic             fflag;
    logic             fwrap;

    wire gctl_wr = i_wr && (i_addr == `HPCC_GCTL_OFS);
    wire halt_wr = gctl_wr && i_wdata[`HPCC_HALT_ALL_BIT];
    wire res_wr  = gctl_wr && i_wdata[`HPCC_RESUME_BIT];
    wire gst_wr  = i_wr && (i_addr == `HPCC_GSTAT_OFS);

    always_comb begin
        rep  = '0;
        resp = fflag && fallow;
        for (int t = 0; t < NT; t++) begin
            if (wrap[t] && ctl[t][`HPCC_ALLOW_BIT]) begin
                rep[t / NUM_CTR] = 1'b1;
            end
            if (wflag[t] && ctl[t][`HPCC_ALLOW_BIT]) begin
                resp = 1'b1;
            end
        end
    end
    assign rep_fix = fwrap && fallow;
    // re-arm only after both levels are cleared
    assign trigger = (|rep || rep_fix) && (gstat == '0) && !gstat_fix && !resp;

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            gfrz <= 1'b0;
        end else if (trigger || halt_wr) begin
            gfrz <= 1'b1;
        end else if (res_wr) begin
            gfrz <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            targets <= '0;
        end else if (gctl_wr) begin
            targets <= i_wdata[TGT_W-1:0];
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_monitor_interrupt <= '0;
        end else begin
            o_monitor_interrupt <= trigger ? targets : '0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            gstat     <= '0;
            gstat_fix <= 1'b0;
        end else begin
            // set wins over a same-cycle clear
            gstat     <= (gstat & ~({NU{gst_wr}} & i_wdata[NU-1:0])) | rep;
            gstat_fix <= (gstat_fix && !(gst_wr && i_wdata[`HPCC_GSTAT_FIX_BIT])) || rep_fix;
        end
    end
    assign o_global_freeze = gfrz;

    // ************************************************
    // hub fixed counter
    // ************************************************
    wire fctl_wr = i_wr && (i_addr == `HPCC_FIXCTL_OFS);
    assign fwrap = fgate && !gfrz && (&fcnt);
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            fgate  <= 1'b0;
            fallow <= 1'b0;
            fflag  <= 1'b0;
        end else begin
            if (fctl_wr) begin
                fgate  <= i_wdata[`HPCC_GATE_BIT];
                fallow <= i_wdata[`HPCC_ALLOW_BIT];
            end
            fflag <= (fflag && !(fctl_wr && i_wdata[`HPCC_FIX_FLAG_BIT])) || fwrap;
        end
    end
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            fcnt <= '0;
        end else if (i_wr && i_addr == `HPCC_FIXLO_OFS) begin
            fcnt <= {fcnt[CTR_W-1:32], i_wdata};
        end else if (i_wr && i_addr == `HPCC_FIXHI_OFS) begin
            fcnt <= {i_wdata[CTR_W-33:0], fcnt[31:0]};
        end else if (fgate && !gfrz) begin
            fcnt <= fcnt + CTR_W'(1);
        end
    end

    // ************************************************
    // per-unit control: freeze and opcode filter
    // ************************************************
    genvar gu;
    generate
        for (gu = 0; gu < NU; gu++) begin : g_unit
            always_ff @(posedge i_clk_sys) begin
                if (i_sys_rst) begin
                    halt_box[gu] <= 1'b0;
                    filt[gu]     <= '0;
                end else begin
                    if (gu < NUM_BOX && i_wr && hpcc_sel(i_addr, gu, `HPCC_UCTL_OFS)) begin
                        halt_box[gu] <= i_wdata[`HPCC_HALT_BOX_BIT];
                    end
                    if (i_wr && hpcc_sel(i_addr, gu, `HPCC_UFILT_OFS)) begin
                        filt[gu] <= i_wdata[7:0];
                    end
                end
            end
        end
    endgenerate

    // ************************************************
    // programmable counters
    // ************************************************
    genvar gt;
    generate
        for (gt = 0; gt < NT; gt++) begin : g_ctr
            localparam int U = gt / NUM_CTR;
            localparam int C = gt % NUM_CTR;
            localparam bit IS_HUB = (U == NUM_BOX);
            localparam logic [5:0] CTL_OFS = `HPCC_CTL_BASE + 6'(4 * C);
            localparam logic [5:0] LO_OFS  = `HPCC_LO_BASE + 6'(8 * C);
            localparam logic [5:0] HI_OFS  = `HPCC_LO_BASE + 6'(8 * C + 4);
            hpcc_byte_t code;
            hpcc_byte_t sub;
            hpcc_lim_t  lim;
            logic       qual;
            logic       qual_d;
            logic       inc;
            logic       run;
            logic       urst_cnt;
            logic       urst_ctl;
            logic       lo_wr;
            logic       hi_wr;
            hpcc_byte_t attr;
            hpcc_byte_t opc;
            assign code = ctl[gt][`HPCC_CODE_LSB +: 8];
            assign sub  = ctl[gt][`HPCC_SUB_LSB +: 8];
            assign lim  = ctl[gt][`HPCC_LIM_LSB +: 4];
            assign attr = attr_s[U*8 +: 8];
            assign opc  = op_s[U*8 +: 8];
            // code 0 selects no event
            assign qual = (code != '0)
                          && ev_s[U*`HPCC_EV_LINES + int'(code[2:0])]
                          && (sub == '0 || (attr & sub) != '0)
                          && (filt[U] == '0 || opc == filt[U])
                          && (lim == '0 || lvl_s[U*`HPCC_LVL_W +: `HPCC_LVL_W] >= lim);
            assign inc  = ctl[gt][`HPCC_RISE_BIT] ? (qual && !qual_d) : qual;
            // hub ignores box freeze
            assign run  = ctl[gt][`HPCC_GATE_BIT] && !gfrz
                          && (IS_HUB || !halt_box[U]);
            assign wrap[gt] = run && inc && (&cnt[gt]);
            assign urst_cnt = !IS_HUB && i_wr && hpcc_sel(i_addr, U, `HPCC_UCTL_OFS)
                              && i_wdata[`HPCC_RST_CNT_BIT];
            assign urst_ctl = !IS_HUB && i_wr && hpcc_sel(i_addr, U, `HPCC_UCTL_OFS)
                              && i_wdata[`HPCC_RST_CTL_BIT];
            assign lo_wr = i_wr && hpcc_sel(i_addr, U, LO_OFS);
            assign hi_wr = i_wr && hpcc_sel(i_addr, U, HI_OFS);

            always_ff @(posedge i_clk_sys) begin
                if (i_sys_rst) begin
                    qual_d <= 1'b0;
                end else begin
                    qual_d <= qual;
                end
            end

            always_ff @(posedge i_clk_sys) begin
                if (i_sys_rst) begin
                    ctl[gt] <= `HPCC_CTL_RST;
                end else if (urst_ctl) begin
                    ctl[gt] <= `HPCC_CTL_RST;
                end else if (i_wr && hpcc_sel(i_addr, U, CTL_OFS)) begin
                    ctl[gt] <= i_wdata;
                end
            end

            always_ff @(posedge i_clk_sys) begin
                if (i_sys_rst) begin
                    cnt[gt] <= '0;
                end else if (urst_cnt) begin
                    cnt[gt] <= '0;
                end else if (lo_wr) begin
                    cnt[gt] <= {cnt[gt][CTR_W-1:32], i_wdata};
                end else if (hi_wr) begin
                    cnt[gt] <= {i_wdata[CTR_W-33:0], cnt[gt][31:0]};
                end else if (run && inc) begin
                    cnt[gt] <= cnt[gt] + CTR_W'(1);
                end
            end

            always_ff @(posedge i_clk_sys) begin
                if (i_sys_rst) begin
                    wflag[gt] <= 1'b0;
                end else begin
                    wflag[gt] <= (wflag[gt] && !(i_wr && hpcc_sel(i_addr, U, `HPCC_USTAT_OFS)
                                  && i_wdata[C])) || wrap[gt];
                end
            end

            property p_frz_hold;
                @(posedge i_clk_sys) disable iff (i_sys_rst)
                (gfrz && !urst_cnt && !lo_wr && !hi_wr) |=> (cnt[gt] == $past(cnt[gt]));
            endproperty
            a_frz_hold: assert property (p_frz_hold)
                else $error("frozen counter changed");

            property p_wrap_flag;
                @(posedge i_clk_sys) disable iff (i_sys_rst)
                (wrap[gt] && !urst_cnt && !lo_wr && !hi_wr) |=> (wflag[gt] && cnt[gt] == '0);
            endproperty
            a_wrap_flag: assert property (p_wrap_flag)
                else $error("wrap did not set flag or zero counter");

            property p_unit_rst;
                @(posedge i_clk_sys) disable iff (i_sys_rst)
                (urst_cnt && urst_ctl) |=> (cnt[gt] == '0 && ctl[gt] == `HPCC_CTL_RST);
            endproperty
            a_unit_rst: assert property (p_unit_rst)
                else $error("unit reset did not clear counter");

            property p_gate_off;
                @(posedge i_clk_sys) disable iff (i_sys_rst)
                (!ctl[gt][`HPCC_GATE_BIT] && !urst_cnt && !lo_wr && !hi_wr)
                    |=> $stable(cnt[gt]);
            endproperty
            a_gate_off: assert property (p_gate_off)
                else $error("gated-off counter changed");
        end
    endgenerate

    // ************************************************
    // register read
    // ************************************************
    hpcc_word_t next_rdata;
    always_comb begin
        next_rdata = '0;
        if (i_addr == `HPCC_GCTL_OFS) begin
            next_rdata[TGT_W-1:0] = targets;
        end else if (i_addr == `HPCC_GSTAT_OFS) begin
            next_rdata[NU-1:0]                = gstat;
            next_rdata[`HPCC_GSTAT_FIX_BIT]   = gstat_fix;
        end else if (i_addr == `HPCC_FIXCTL_OFS) begin
            next_rdata[`HPCC_GATE_BIT]        = fgate;
            next_rdata[`HPCC_ALLOW_BIT]       = fallow;
            next_rdata[`HPCC_FIX_FLAG_BIT]    = fflag;
        end else if (i_addr == `HPCC_FIXLO_OFS) begin
            next_rdata = fcnt[31:0];
        end else if (i_addr == `HPCC_FIXHI_OFS) begin
            next_rdata[CTR_W-33:0] = fcnt[CTR_W-1:32];
        end
        for (int u = 0; u < NU; u++) begin
            if (u < NUM_BOX && hpcc_sel(i_addr, u, `HPCC_UCTL_OFS)) begin
                next_rdata[`HPCC_HALT_BOX_BIT] = halt_box[u];
            end else if (hpcc_sel(i_addr, u, `HPCC_UFILT_OFS)) begin
                next_rdata[7:0] = filt[u];
            end else if (hpcc_sel(i_addr, u, `HPCC_USTAT_OFS)) begin
                next_rdata[NUM_CTR-1:0] = wflag[u*NUM_CTR +: NUM_CTR];
            end
        end
        for (int t = 0; t < NT; t++) begin
            if (hpcc_sel(i_addr, t / NUM_CTR, `HPCC_CTL_BASE + 6'(4 * (t % NUM_CTR)))) begin
                next_rdata = ctl[t];
            end else if (hpcc_sel(i_addr, t / NUM_CTR,
                                  `HPCC_LO_BASE + 6'(8 * (t % NUM_CTR)))) begin
                next_rdata = cnt[t][31:0];
            end else if (hpcc_sel(i_addr, t / NUM_CTR,
                                  `HPCC_LO_BASE + 6'(8 * (t % NUM_CTR) + 4))) begin
                next_rdata[CTR_W-33:0] = cnt[t][CTR_W-1:32];
            end
        end
    end
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_rdata <= '0;
        end else begin
            o_rdata <= i_rd ? next_rdata : '0;
        end
    end

    // ************************************************
    // checks
    // ************************************************
    property p_rep_freeze;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        trigger |=> o_global_freeze;
    endproperty
    a_rep_freeze: assert property (p_rep_freeze)
        else $error("report did not freeze");

    property p_irq;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        trigger |=> (o_monitor_interrupt == $past(targets)) ##1 (o_monitor_interrupt == '0
                     || $past(trigger));
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt not sent to target cores");

    property p_halt_all;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        halt_wr |=> o_global_freeze;
    endproperty
    a_halt_all: assert property (p_halt_all)
        else $error("halt write did not freeze");

    property p_resume;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        (res_wr && !halt_wr && !trigger) |=> !o_global_freeze;
    endproperty
    a_resume: assert property (p_resume)
        else $error("resume did not release freeze");

    property p_w1c;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        (gst_wr && i_wdata[0] && !rep[0]) |=> !gstat[0];
    endproperty
    a_w1c: assert property (p_w1c)
        else $error("status bit not cleared by write of 1");

    property p_no_refreeze;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        ((gstat != '0) && !halt_wr) |=> !$rose(o_global_freeze);
    endproperty
    a_no_refreeze: assert property (p_no_refreeze)
        else $error("freeze raised while flags still set");

    property p_fixed;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        (fgate && !gfrz && !i_wr) |=> (fcnt == $past(fcnt) + CTR_W'(1));
    endproperty
    a_fixed: assert property (p_fixed)
        else $error("fixed counter did not advance");

    property p_report_rec;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        rep[0] |=> gstat[0] ##1 (gstat[0] || $past(gst_wr));
    endproperty
    a_report_rec: assert property (p_report_rec)
        else $error("report not recorded");
endmodule

// >>> inc/hpcc_cfg.svh
// address map, field positions and reset values of the counter control block
`ifndef HPCC_CFG_SVH
`define HPCC_CFG_SVH
`define HPCC_ADDR_W          12
`define HPCC_GCTL_OFS        12'h000
`define HPCC_GSTAT_OFS       12'h004
`define HPCC_FIXCTL_OFS      12'h008
`define HPCC_FIXLO_OFS       12'h00c
`define HPCC_FIXHI_OFS       12'h010
`define HPCC_UNIT_SHIFT      6
`define HPCC_UCTL_OFS        6'h00
`define HPCC_USTAT_OFS       6'h04
`define HPCC_UFILT_OFS       6'h08
`define HPCC_CTL_BASE        6'h10
`define HPCC_LO_BASE         6'h20
`define HPCC_HALT_ALL_BIT    31
`define HPCC_RESUME_BIT      29
`define HPCC_RST_CNT_BIT     0
`define HPCC_RST_CTL_BIT     1
`define HPCC_HALT_BOX_BIT    8
`define HPCC_FIX_FLAG_BIT    0
`define HPCC_GSTAT_FIX_BIT   31
`define HPCC_CODE_LSB        0
`define HPCC_SUB_LSB         8
`define HPCC_RISE_BIT        18
`define HPCC_ALLOW_BIT       20
`define HPCC_GATE_BIT        22
`define HPCC_LIM_LSB         24
`define HPCC_CTL_RST         32'h0000_0000
`define HPCC_EV_LINES        8
`define HPCC_LVL_W           4
`endif

// >>> inc/hpcc_pkg.sv
// types shared by the counter control block
package hpcc_pkg;
    typedef logic [7:0] hpcc_byte_t;
    typedef logic [3:0] hpcc_lim_t;
    typedef logic [31:0] hpcc_word_t;
endpackage

// >>> dv/hpcc_event_src.sv
// event source model standing in for the monitored units
`timescale 1ns/10ps
module hpcc_event_src #(
    parameter int NU = 3
) (
    input  wire logic          i_clk,
    input  wire logic          i_on,
    output logic [NU*8-1:0]    o_events = '0,
    output logic [NU*8-1:0]    o_attr = '0,
    output logic [NU*8-1:0]    o_opcode = '0,
    output logic [NU*4-1:0]    o_level = '0
);
    // all lines busy while on; qualifiers wander every cycle
    always @(posedge i_clk) begin
        o_events <= i_on ? '1 : '0;
        o_attr <= (NU*8)'($urandom);
        o_opcode <= (NU*8)'($urandom);
        o_level <= (NU*4)'($urandom);
    end
endmodule

// >>> dv/hpcc_tb_top.sv
// self-checking bench for the counter control block
`timescale 1ns/10ps
`include "hpcc_cfg.svh"
module hpcc_tb_top;
    import hpcc_pkg::*;
    // ****************************************
    // signals
    // ****************************************
    localparam hpcc_word_t GATE = 32'h0040_0000;
    localparam hpcc_word_t ALLOW = 32'h0010_0000;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [11:0] addr = 12'h000;
    hpcc_word_t  wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        ev_on = 1'b0;
    logic [23:0] ev;
    logic [23:0] attr;
    logic [23:0] opc;
    logic [11:0] lvl;
    hpcc_word_t  rdata;
    logic        frz;
    logic [17:0] irq;
    logic [17:0] irq_val = 18'h0;
    logic [17:0] tgt;
    hpcc_word_t  a;
    int fails = 0;
    int compares = 0;
    int cycles = 0;
    int n_irq = 0;
    always #2 clk = ~clk;
    hpcc_event_src #(.NU(3)) src (.i_clk(clk), .i_on(ev_on), .o_events(ev),
        .o_attr(attr), .o_opcode(opc), .o_level(lvl));
    hpcc_top dut (.i_clk_sys(clk), .i_sys_rst(rst), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .i_unit_events(ev), .i_unit_attr(attr),
        .i_unit_opcode(opc), .i_unit_level(lvl), .o_rdata(rdata),
        .o_global_freeze(frz), .o_monitor_interrupt(irq));
    // ****************************************
    // tasks
    // ****************************************
    task automatic finish_test();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (irq !== 18'h0) begin
            n_irq <= n_irq + 1;
            irq_val <= irq;
        end
        if (cycles == 4000) begin
            fails = fails + 1;
            finish_test();
        end
    end
    task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr_reg(input logic [11:0] ad, input hpcc_word_t d);
        addr <= ad;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd_reg(input logic [11:0] ad, output hpcc_word_t d);
        addr <= ad;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        d = rdata;
    endtask
    // growth of a count over two reads issued two cycles apart
    task automatic rd2(input logic [11:0] ad, output hpcc_word_t d);
        hpcc_word_t x;
        rd_reg(ad, x);
        rd_reg(ad, d);
        d = d - x;
    endtask
    task automatic arm(input logic [11:0] base, input int c, input hpcc_word_t ctl);
        wr_reg(base + 12'h20 + 12'(8 * c), 32'hffff_fffd);
        wr_reg(base + 12'h24 + 12'(8 * c), 32'h0000_ffff);
        wr_reg(base + 12'h10 + 12'(4 * c), ctl);
    endtask
    task automatic burst_to_freeze();
        ev_on <= 1'b1;
        repeat (30) begin
            @(posedge clk);
            if (frz === 1'b1)
                break;
        end
        ev_on <= 1'b0;
        @(posedge clk);
    endtask
    // ****************************************
    // tests
    // ****************************************
    initial begin
        a = $urandom(32'h6363);
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd_reg(12'h060, a);
        chk("box count", 0, a);
        rd2(12'h060, a);
        chk("box idle", 0, a);
        chk("freeze", 0, frz);
        $display("test reset done");
        wr_reg(12'h008, GATE);
        rd2(12'h00c, a);
        chk("fixed run", 2, a);
        wr_reg(12'h000, 32'h8000_0000);
        chk("freeze", 1, frz);
        rd2(12'h00c, a);
        chk("fixed held", 0, a);
        wr_reg(12'h000, 32'h2000_0000);
        chk("freeze", 0, frz);
        rd2(12'h00c, a);
        chk("fixed resumed", 2, a);
        $display("test freeze done");
        tgt = 18'($urandom) | 18'h1;
        wr_reg(12'h000, {14'h0, tgt});
        arm(12'h040, 0, GATE | ALLOW | 32'h1);
        arm(12'h040, 1, GATE | 32'h1);
        burst_to_freeze();
        chk("freeze", 1, frz);
        chk("irq count", 1, n_irq);
        chk("irq mask", tgt, irq_val);
        rd_reg(12'h004, a);
        chk("global status", 1, a);
        rd_reg(12'h044, a);
        chk("wrap flags", 3, a);
        rd_reg(12'h084, a);
        chk("other box flags", 0, a);
        rd2(12'h060, a);
        chk("frozen count", 0, a);
        $display("test overflow done");
        // core mask is rewritten by every control write, so keep it
        wr_reg(12'h000, 32'h2000_0000 | {14'h0, tgt});
        arm(12'h040, 0, GATE | ALLOW | 32'h1);
        ev_on <= 1'b1;
        repeat (12) @(posedge clk);
        ev_on <= 1'b0;
        chk("no refreeze", 0, frz);
        chk("irq count", 1, n_irq);
        wr_reg(12'h004, 32'h0);
        rd_reg(12'h004, a);
        chk("status kept", 1, a);
        wr_reg(12'h004, 32'h1);
        wr_reg(12'h044, 32'h3);
        rd_reg(12'h004, a);
        chk("status cleared", 0, a);
        arm(12'h040, 0, GATE | ALLOW | 32'h1);
        burst_to_freeze();
        chk("irq count", 2, n_irq);
        $display("test rearm done");
        wr_reg(12'h000, 32'h2000_0000);
        wr_reg(12'h090, GATE | 32'h1);
        wr_reg(12'h080, 32'h100);
        ev_on <= 1'b1;
        repeat (4) @(posedge clk);
        wr_reg(12'h0d0, GATE);
        rd2(12'h0e0, a);
        chk("hub idle code", 0, a);
        wr_reg(12'h0d0, GATE | 32'h1);
        rd2(12'h0e0, a);
        chk("hub counts", 2, a);
        wr_reg(12'h054, GATE | 32'h0004_0001);
        rd2(12'h068, a);
        chk("rising only", 0, a);
        rd2(12'h0a0, a);
        chk("box halted", 0, a);
        rd2(12'h060, a);
        chk("other box runs", 2, a);
        wr_reg(12'h080, 32'h0);
        repeat (4) @(posedge clk);
        rd2(12'h0a0, a);
        chk("box released", 2, a);
        wr_reg(12'h080, 32'h3);
        rd_reg(12'h0a0, a);
        chk("cleared count", 0, a);
        rd_reg(12'h090, a);
        chk("cleared ctl", 0, a);
        ev_on <= 1'b0;
        $display("test box control done");
        finish_test();
    end
endmodule
